/* File: logic/psp_cfg.svh */
// register offsets, field positions, reset values and constants for the phase and pin map bank
// Summary of operation
// - each phase register low 13 bits hold signed whole-period shift, reset zero
// - zero shift leaves output alone; negative delays, positive advances by periods
// - one register's period and eighth-turn settings drive its whole divider path
// - top three bits of each phase register pick a 45-degree step offset
// - codes 000, 001, 010, 011 give 0, -45, -90, -135 degrees
// - codes 100, 101, 111 give 180, +135, +45 degrees
// - code 110 gives +90 degrees
// - reference register bit 0 set disables oscillator output driver, reset zero
// - read-only secondary revision byte completes revision at address zero
// - pin function low seven bits index the selected table bit
// - control table and status table are each 128 bits
// - pin function bit 7: zero is control input, one is status output
// - both pin function registers reset to zero, both pins control inputs to table bit 0
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PSP_CH0_C_HI_ADDR   8'hbf
`define PSP_CH0_D_HI_ADDR   8'hc1
`define PSP_REF_DRV_ADDR    8'hc3
`define PSP_REV_LOW_ADDR    8'hc6
`define PSP_CH1_C_HI_ADDR   8'hc7
`define PSP_CH1_D_HI_ADDR   8'hc9
`define PSP_PIN0_FUNC_ADDR  8'he0
`define PSP_PIN1_FUNC_ADDR  8'he1

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PSP_PERIOD_MSB      12
`define PSP_TURN_LSB        13
`define PSP_TURN_MSB        15
`define PSP_ROLE_BIT        7
`define PSP_DRV_DIS_BIT     0
`define PSP_PHASE_RST       16'h0000
`define PSP_BYTE_RST        8'h00
`define PSP_TABLE_BITS      128

`endif

/* File: logic/psp_pkg.sv */
// types and the eighth-turn decode shared by the phase and pin map bank
package psp_pkg;

   typedef logic signed [12:0] psp_period_t;
   typedef logic signed [3:0]  psp_eighths_t;

   typedef enum logic {
      PSP_ROLE_CONTROL,
      PSP_ROLE_STATUS
   } psp_role_t;

   // eighth-turn code to signed count of 45-degree steps
   function automatic psp_eighths_t psp_turn_decode(input logic [2:0] code);
      psp_eighths_t r;
      r = 4'sd0;
      case (code)
         3'b000:  r = 4'sd0;
         3'b001:  r = -4'sd1;
         3'b010:  r = -4'sd2;
         3'b011:  r = -4'sd3;
         3'b100:  r = 4'sd4;
         3'b101:  r = 4'sd3;
         3'b110:  r = 4'sd2;
         3'b111:  r = 4'sd1;
         default: r = 4'sd0;
      endcase
      return r;
   endfunction

endpackage

/* File: logic/psp_phase_reg.sv */
// one 16-bit phase register split over two byte addresses
`timescale 1ns/1ps
`include "psp_cfg.svh"
module psp_phase_reg
   import psp_pkg::*;
#(
   parameter logic [7:0] HI_ADDR = 8'hbf
) (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        wr_en,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   output logic      [15:0] value,
   output logic             pending
);

   logic [15:0] value_r, value_nxt;
   logic [7:0]  hi_stage_r, hi_stage_nxt;
   logic        pend_r, pend_nxt;
   logic [7:0]  lo_addr;

   assign lo_addr = HI_ADDR + 8'h01;

   // upper byte waits in a stage so outputs never show a half-written value
   always_comb begin
      value_nxt    = value_r;
      hi_stage_nxt = hi_stage_r;
      pend_nxt     = pend_r;
      if (wr_en && addr == HI_ADDR) begin
         hi_stage_nxt = wdata;
         pend_nxt     = 1'b1;
      end else if (wr_en && addr == lo_addr) begin
         value_nxt = {hi_stage_r, wdata};
         pend_nxt  = 1'b0;
      end
   end

   // state registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         value_r    <= `PSP_PHASE_RST;
         hi_stage_r <= `PSP_BYTE_RST;
         pend_r     <= 1'b0;
      end else begin
         value_r    <= value_nxt;
         hi_stage_r <= hi_stage_nxt;
         pend_r     <= pend_nxt;
      end
   end

   assign value   = value_r;
   assign pending = pend_r;

endmodule // psp_phase_reg

/* File: logic/psp_bank.sv */
// phase shift and pin map register bank behind the host serial port's byte register port
`timescale 1ns/1ps
`include "psp_cfg.svh"
module psp_bank
   import psp_pkg::*;
#(
   parameter logic [7:0] REV_LOW = 8'h5a  // arbitrary value
) (
   input  wire logic          mclk,
   input  wire logic          rstn,
   // byte register port from the serial port logic, same clock
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output logic      [7:0]    reg_rdata,
   output logic               reg_rvalid,
   // per-path shift settings, index 0..3 = ch0 C, ch0 D, ch1 C, ch1 D
   output logic      [51:0]   period_offset,
   output logic      [15:0]   eighth_turn,
   output logic      [67:0]   total_eighths,
   output logic               osc_output_driver_en,
   // mapping tables
   input  wire logic [127:0]  status_table,
   output logic      [127:0]  control_table,
   // two general-purpose pins
   input  wire logic          pin_zero_in,
   output logic               pin_zero_out,
   output logic               pin_zero_oe_n,
   input  wire logic          pin_one_in,
   output logic               pin_one_out,
   output logic               pin_one_oe_n
);

   // ----------------------------------------------------------------
   // phase registers
   // ----------------------------------------------------------------
   // paths are handled alike; only the upper-byte address differs, so a
   // fifth path would be one more entry in the address list and the loops
   // limitation: settings act in the cycle after the low byte lands,
   // there is no shadow that waits for a divider edge
   // upper-byte addresses of the four paths, in port order
   localparam logic [7:0] HI_ADDRS [4] = '{`PSP_CH0_C_HI_ADDR, `PSP_CH0_D_HI_ADDR,
                                           `PSP_CH1_C_HI_ADDR, `PSP_CH1_D_HI_ADDR};
   logic [15:0] phase [4];

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_path
         psp_phase_reg #(.HI_ADDR(HI_ADDRS[g])) u_reg (
            .mclk    (mclk),
            .rstn    (rstn),
            .wr_en   (reg_wr),
            .addr    (reg_addr),
            .wdata   (reg_wdata),
            .value   (phase[g]),
            .pending ()  // staged upper byte not needed here
         );
         // signed views of the two fields of this path's register
         psp_period_t  per;
         psp_eighths_t turn;
         assign per  = psp_period_t'(phase[g][`PSP_PERIOD_MSB:0]);
         assign turn = psp_turn_decode(phase[g][`PSP_TURN_MSB:`PSP_TURN_LSB]);
         // one setting per path feeds every clock of that path
         assign period_offset[g*13 +: 13] = per;
         assign eighth_turn[g*4 +: 4]     = turn;
         // negative delays, positive advances, in eighths of a period
         // shift times eight plus the step count needs the seventeenth bit
         assign total_eighths[g*17 +: 17] = 17'(signed'({per, 3'b000})) + 17'(turn);
      end
   endgenerate

   // ----------------------------------------------------------------
   // byte registers: reference driver and pin functions
   // ----------------------------------------------------------------
   logic [7:0] ref_drv_r, ref_drv_nxt;
   logic [7:0] pin0_func_r, pin0_func_nxt;
   logic [7:0] pin1_func_r, pin1_func_nxt;

   // plain byte writes; reserved reference bits are not stored
   // so they read back as zero whatever software wrote; the revision byte
   // has no store at all and ignores writes
   always_comb begin
      ref_drv_nxt   = ref_drv_r;
      pin0_func_nxt = pin0_func_r;
      pin1_func_nxt = pin1_func_r;
      if (reg_wr) begin
         case (reg_addr)
            `PSP_REF_DRV_ADDR:   ref_drv_nxt   = {7'h00, reg_wdata[`PSP_DRV_DIS_BIT]};
            `PSP_PIN0_FUNC_ADDR: pin0_func_nxt = reg_wdata;
            `PSP_PIN1_FUNC_ADDR: pin1_func_nxt = reg_wdata;
            default:             ;
         endcase
      end
   end

   // byte register storage
   // every byte register clears on reset; none is loaded from elsewhere
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ref_drv_r   <= `PSP_BYTE_RST;
         pin0_func_r <= `PSP_BYTE_RST;
         pin1_func_r <= `PSP_BYTE_RST;
      end else begin
         ref_drv_r   <= ref_drv_nxt;
         pin0_func_r <= pin0_func_nxt;
         pin1_func_r <= pin1_func_nxt;
      end
   end

   // set bit turns the driver off, for use with an external oscillator
   // reset leaves the driver on, the safe choice for a crystal
   assign osc_output_driver_en = ~ref_drv_r[`PSP_DRV_DIS_BIT];

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [7:0] rdata_r, rdata_nxt;
   logic       rvalid_r, rvalid_nxt;

   // registered answer one cycle after the strobe; unmapped reads give zero
   // a read in the same cycle as a write returns the value before that write
   always_comb begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = reg_rd;
      if (reg_rd) begin
         rdata_nxt = 8'h00;
         // phase registers answer on both of their byte addresses
         for (int i = 0; i < 4; i++) begin
            if (reg_addr == HI_ADDRS[i])
               rdata_nxt = phase[i][15:8];
            else if (reg_addr == HI_ADDRS[i] + 8'h01)
               rdata_nxt = phase[i][7:0];
         end
         case (reg_addr)
            `PSP_REF_DRV_ADDR:   rdata_nxt = ref_drv_r;
            `PSP_REV_LOW_ADDR:   rdata_nxt = REV_LOW;
            `PSP_PIN0_FUNC_ADDR: rdata_nxt = pin0_func_r;
            `PSP_PIN1_FUNC_ADDR: rdata_nxt = pin1_func_r;
            default:             ;
         endcase
      end
   end

   // read registers
   // rdata holds between reads so a slow master may sample it late
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign reg_rdata  = rdata_r;
   assign reg_rvalid = rvalid_r;

   // ----------------------------------------------------------------
   // pin synchronisers and table mapping
   // ----------------------------------------------------------------
   // bit 0 carries pin zero and bit 1 pin one through both stages
   logic [1:0]   pin_meta_r, pin_sync_r;
   logic [127:0] ctrl_r, ctrl_nxt;
   logic         pin0_out_r, pin0_out_nxt;
   logic         pin1_out_r, pin1_out_nxt;
   psp_role_t    role0, role1;
   logic [6:0]   idx0, idx1;

   // function register fields, decoded once and shared by both processes
   assign idx0  = pin0_func_r[6:0];
   assign idx1  = pin1_func_r[6:0];
   assign role0 = psp_role_t'(pin0_func_r[`PSP_ROLE_BIT]);
   assign role1 = psp_role_t'(pin1_func_r[`PSP_ROLE_BIT]);

   // two flops on each pin before the table sees it
   // the first stage may go metastable, so only the second stage is read
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_r <= 2'b00;
         pin_sync_r <= 2'b00;
      end else begin
         pin_meta_r <= {pin_one_in, pin_zero_in};
         pin_sync_r <= pin_meta_r;
      end
   end

   // input pins overwrite their control bit; pin one wins a shared index
   // control bits no pin points at keep their value, so moving a pin to a new
   // index leaves the last level it wrote behind in the old bit
   always_comb begin
      ctrl_nxt     = ctrl_r;
      pin0_out_nxt = status_table[idx0];
      pin1_out_nxt = status_table[idx1];
      if (role0 == PSP_ROLE_CONTROL)
         ctrl_nxt[idx0] = pin_sync_r[0];
      if (role1 == PSP_ROLE_CONTROL)
         ctrl_nxt[idx1] = pin_sync_r[1];
   end

   // table and pin output registers, full 128-bit reach of the index
   // status reaches the pin one cycle after the table bit changes
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r     <= '0;
         pin0_out_r <= 1'b0;
         pin1_out_r <= 1'b0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         pin0_out_r <= pin0_out_nxt;
         pin1_out_r <= pin1_out_nxt;
      end
   end

   assign control_table = ctrl_r;
   assign pin_zero_out  = pin0_out_r;
   assign pin_one_out   = pin1_out_r;
   // enable low while the pin drives status out
   // reset puts both pins in the control role, so neither drives its pin
   assign pin_zero_oe_n = (role0 != PSP_ROLE_STATUS);
   assign pin_one_oe_n  = (role1 != PSP_ROLE_STATUS);

endmodule // psp_bank

/* File: verification/psp_bank_asserts.sv */
// checker for the phase and pin map register bank
`timescale 1ns/1ps
module psp_bank_asserts
   import psp_pkg::*;
#(
   parameter logic [7:0] REV_LOW = 8'h5a
) (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic [51:0] period_offset,
   input wire logic [15:0] eighth_turn,
   input wire logic [67:0] total_eighths,
   input wire logic        osc_output_driver_en,
   input wire logic        pin_zero_oe_n,
   input wire logic        pin_one_oe_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // last byte on the write port, so a commit can see its upper byte
   logic [7:0] wd_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wd_r <= 8'h00;
      end else begin
         wd_r <= reg_wdata;
      end
   end

   // ----
   // two-step phase write on path 1
   // ----
   sequence s_hi_d; reg_wr && reg_addr == 8'hc1; endsequence
   sequence s_lo_d; reg_wr && reg_addr == 8'hc2; endsequence

   a_commit_two: assert property (s_hi_d ##1 s_lo_d |=>
      period_offset[25:13] == {$past(wd_r[4:0]), $past(reg_wdata)}) else $error("phase commit mismatch");
   a_total_sum: assert property (total_eighths[33:17] ==
      {period_offset[25], period_offset[25:13], 3'b000} + {{13{eighth_turn[7]}}, eighth_turn[7:4]})
      else $error("combined shift mismatch");
   a_rev_read: assert property (reg_rd && reg_addr == 8'hc6 |=>
      reg_rvalid && reg_rdata == REV_LOW) else $error("revision read mismatch");
   a_drv_bit: assert property (reg_wr && reg_addr == 8'hc3 |=>
      osc_output_driver_en == !$past(reg_wdata[0])) else $error("driver enable mismatch");
   a_pin_role: assert property (reg_wr && reg_addr == 8'he0 |=>
      pin_zero_oe_n == !$past(reg_wdata[7])) else $error("pin zero role mismatch");
   a_pin1_role: assert property (reg_wr && reg_addr == 8'he1 |=>
      pin_one_oe_n == !$past(reg_wdata[7])) else $error("pin one role mismatch");
   a_reset_vals: assert property ($rose(rstn) |->
      pin_zero_oe_n && pin_one_oe_n && osc_output_driver_en && period_offset == '0) else $error("reset state");
   // settings move only on a write; guards against free-running updates
   a_hold_quiet: assert property (!reg_wr |=>
      $stable(period_offset) && $stable(pin_zero_oe_n) && $stable(osc_output_driver_en)) else $error("moved");
   a_read_pulse: assert property (!reg_rd |=>
      !reg_rvalid && $stable(reg_rdata)) else $error("read answer without request");
endmodule  // psp_bank_asserts

bind psp_bank psp_bank_asserts #(.REV_LOW(REV_LOW)) u_asserts (
   .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .period_offset(period_offset), .eighth_turn(eighth_turn), .total_eighths(total_eighths),
   .osc_output_driver_en(osc_output_driver_en), .pin_zero_oe_n(pin_zero_oe_n), .pin_one_oe_n(pin_one_oe_n)
);

/* File: verification/test_psp_bank.sv */
// self-checking bench for the phase and pin map register bank
`timescale 1ns/1ps
module test_psp_bank;
   localparam logic [7:0] REV = 8'h3c;  // arbitrary value
   logic         mclk = 1'b0;
   logic         rstn = 1'b0;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [7:0]   reg_addr = 8'h00;
   logic [7:0]   reg_wdata = 8'h00;
   logic [127:0] status_table = '0;
   logic         pin_zero_in = 1'b0;
   logic         pin_one_in = 1'b0;
   logic [7:0]   reg_rdata;
   logic         reg_rvalid;
   logic [51:0]  period_offset;
   logic [15:0]  eighth_turn;
   logic [67:0]  total_eighths;
   logic         osc_output_driver_en;
   logic [127:0] control_table;
   logic         pin_zero_out;
   logic         pin_zero_oe_n;
   logic         pin_one_out;
   logic         pin_one_oe_n;
   int           err_count = 0;
   int           cmp_count = 0;
   logic [7:0]   base [4] = '{8'hbf, 8'hc1, 8'hc7, 8'hc9};
   logic [3:0]   turn [8] = '{4'h0, 4'hf, 4'he, 4'hd, 4'h4, 4'h3, 4'h2, 4'h1};

   always #50 mclk = ~mclk;

   psp_bank #(.REV_LOW(REV)) dut_u (
      .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .period_offset(period_offset), .eighth_turn(eighth_turn), .total_eighths(total_eighths),
      .osc_output_driver_en(osc_output_driver_en), .status_table(status_table),
      .control_table(control_table), .pin_zero_in(pin_zero_in), .pin_zero_out(pin_zero_out),
      .pin_zero_oe_n(pin_zero_oe_n), .pin_one_in(pin_one_in), .pin_one_out(pin_one_out),
      .pin_one_oe_n(pin_one_oe_n)
   );

   // ----
   // access and compare tasks; strobes move on the falling edge only
   // ----
   task automatic chk(string name, logic [127:0] seen, logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask

   // upper byte then lower byte on consecutive edges, strobe held high between them
   task automatic wr16(logic [7:0] a, logic [15:0] v);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v[15:8];
      @(negedge mclk);
      reg_addr = a + 8'h01;
      reg_wdata = v[7:0];
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk("rvalid", reg_rvalid, 1'b1);
      chk($sformatf("rdata %h", a), reg_rdata, exp);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----
   // main sequence
   // ----
   initial begin
      int p;
      logic [12:0] pv;
      repeat (16) @(negedge mclk);
      rstn = 1'b1;
      chk("period_offset", period_offset, '0);
      chk("drv_en", osc_output_driver_en, 1'b1);
      chk("oe_n", {pin_one_oe_n, pin_zero_oe_n}, 2'b11);
      chk("control_table", control_table, '0);
      foreach (base[i]) rd(base[i] + 8'h01, 8'h00);
      rd(8'he0, 8'h00);
      rd(8'he1, 8'h00);
      // every eighth-turn code once, spread over the four paths
      for (int k = 0; k < 8; k++) begin
         p = k % 4;
         pv = 13'h1000 + 13'(k * 1170);
         wr16(base[p], {3'(k), pv});
         chk("period", period_offset[13*p +: 13], pv);
         chk("eighths", eighth_turn[4*p +: 4], turn[k]);
         chk("total", total_eighths[17*p +: 17],
             17'({pv[12], pv, 3'b000} + {{13{turn[k][3]}}, turn[k]}));
         rd(base[p], {3'(k), pv[12:8]});
      end
      // lower byte alone reuses the staged upper byte; upper alone commits nothing
      wr16(8'hc1, 16'he010);
      wr(8'hc2, 8'h22);
      rd(8'hc1, 8'he0);
      rd(8'hc2, 8'h22);
      chk("period", period_offset[25:13], 13'h0022);
      wr(8'hc1, 8'h20);
      chk("period", period_offset[25:13], 13'h0022);
      chk("eighths", eighth_turn[7:4], 4'h1);
      wr(8'hc3, 8'hff);
      chk("drv_en", osc_output_driver_en, 1'b0);
      rd(8'hc3, 8'h01);
      wr(8'hc3, 8'h00);
      chk("drv_en", osc_output_driver_en, 1'b1);
      wr(8'hc6, 8'hff);
      rd(8'hc6, REV);
      wr(8'hd0, 8'hff);
      rd(8'hd0, 8'h00);
      // status role, index 5 and the top index 127
      wr(8'he0, 8'h85);
      wr(8'he1, 8'hff);
      chk("oe_n", {pin_one_oe_n, pin_zero_oe_n}, 2'b00);
      for (int v = 0; v < 2; v++) begin
         status_table[5] = v[0];
         status_table[4] = !v[0];
         status_table[127] = !v[0];
         repeat (2) @(negedge mclk);
         chk("pin_zero_out", pin_zero_out, v[0]);
         chk("pin_one_out", pin_one_out, !v[0]);
      end
      // control role, index 0 and index 127
      wr(8'he0, 8'h00);
      wr(8'he1, 8'h7f);
      rd(8'he1, 8'h7f);
      pin_zero_in = 1'b1;
      pin_one_in = 1'b1;
      repeat (4) @(negedge mclk);
      chk("control_table", control_table, {1'b1, 126'd0, 1'b1});
      chk("oe_n", {pin_one_oe_n, pin_zero_oe_n}, 2'b11);
      pin_zero_in = 1'b0;
      repeat (4) @(negedge mclk);
      chk("control_bit0", control_table[0], 1'b0);
      complete_run();
   end

   // hang guard, well past the roughly 120 cycles the tests need
   initial begin
      repeat (3000) @(posedge mclk);
      err_count++;
      complete_run();
   end
endmodule  // test_psp_bank
